/* File: shared/cjc_params.svh */
`ifndef CJC_PARAMS_SVH
`define CJC_PARAMS_SVH
`define CJC_IR_LEN 10
`define CJC_BSR_LEN 174
`define CJC_OP_SAMPLE 10'h055
`define CJC_OP_EXTEST 10'h000
`define CJC_OP_BYPASS 10'h3ff
`define CJC_OP_IDCODE 10'h059
`define CJC_OP_USERCODE 10'h079
`define CJC_OP_START_RELOAD 10'h061
`define CJC_OP_HOLD_RELOAD 10'h065
`define CJC_IR_CAPTURE 10'h001
`define CJC_CLK_MHZ 25
`define CJC_POR_SHORT_US 2000
`define CJC_POR_LONG_US 100000
`define CJC_POR_SHORT_CYC (`CJC_POR_SHORT_US * `CJC_CLK_MHZ)
`define CJC_POR_LONG_CYC (`CJC_POR_LONG_US * `CJC_CLK_MHZ)
`endif

/* File: shared/cjc_pkg.sv */
package cjc_pkg;
   typedef enum logic [3:0] {
      TEST_LOGIC_RESET, RUN_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
      PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR,
      EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
   } cjc_tap_e;
   typedef enum logic [1:0] {POR_WAIT, POR_EXTEND, POR_CONFIG, POR_IDLE}
      cjc_por_e;
   typedef struct packed {
      logic tck_tms;
      logic tdi;
   } cjc_tap_in_s;
endpackage

/* File: verilog/cjc_config_jtag_control.sv */
`timescale 1ns/1ns
`include "cjc_params.svh"
module cjc_config_jtag_control #(
   parameter int unsigned POR_SHORT_CYC = `CJC_POR_SHORT_CYC,
   parameter int unsigned POR_LONG_CYC = `CJC_POR_LONG_CYC,
   parameter logic [31:0] ID_VALUE = 32'h1234_5679 // arbitrary value
) (
   input wire logic clock, // system clock, 25 MHz
   input wire logic srst, // synchronous reset, high
   input wire logic tck, // jtag clock
   input wire logic tms, // jtag mode select
   input wire logic tdi, // jtag data in
   output logic tdo, // jtag data out
   output logic tdo_oe_n, // tdo enable, low drives
   input wire logic [31:0] user_code, // programmable user code
   input wire logic [`CJC_BSR_LEN-1:0] pin_levels, // device pin states
   output logic [`CJC_BSR_LEN-1:0] pin_drive, // boundary drive pattern
   output logic pin_test_en, // external test owns pins
   output logic reload_req_o, // reload request, always 0
   output logic reload_req_oe_n, // low pulls reload request low
   input wire logic por_delay_select, // high 2 ms, low 100 ms
   input wire logic enable_in, // reset/enable line level
   output logic enable_o, // reset/enable drive, always 0
   output logic enable_oe_n, // low holds enable line low
   input wire logic load_done, // fpga load-complete line
   output logic config_start, // configuration may begin, level
   output logic config_idle // locked idle, clock and data quiet
);
   cjc_pkg::cjc_tap_e tap_ff, nxt_tap;
   logic [`CJC_IR_LEN-1:0] ir_shift_ff, ir_ff;
   logic [`CJC_BSR_LEN-1:0] bsr_ff, bsr_upd_ff;
   logic [31:0] dr32_ff;
   logic bypass_ff, tdo_ff, tdo_en_ff, hold_ff;
   logic [1:0] sel_sync_ff, en_sync_ff, done_sync_ff;
   logic [1:0] req_sync_ff;
   cjc_pkg::cjc_por_e por_ff;
   logic [31:0] por_cnt_ff;
   logic en_prev_ff;
   logic in_start, in_hold;
   logic in_sample, in_extest, in_idcode, in_user, in_bypass;
   logic in_boundary;
   logic tlr, cap_dr, shf_dr, upd_dr;
   logic req_tck_ff;
   logic [31:0] por_lim_ff;
   logic en_rise;

   // tap state sequence on tms
   always_comb begin
      nxt_tap = tap_ff;
      case (tap_ff)
         cjc_pkg::TEST_LOGIC_RESET:
            nxt_tap = tms ? cjc_pkg::TEST_LOGIC_RESET : cjc_pkg::RUN_IDLE;
         cjc_pkg::RUN_IDLE:
            nxt_tap = tms ? cjc_pkg::SELECT_DR : cjc_pkg::RUN_IDLE;
         cjc_pkg::SELECT_DR:
            nxt_tap = tms ? cjc_pkg::SELECT_IR : cjc_pkg::CAPTURE_DR;
         cjc_pkg::CAPTURE_DR:
            nxt_tap = tms ? cjc_pkg::EXIT1_DR : cjc_pkg::SHIFT_DR;
         cjc_pkg::SHIFT_DR:
            nxt_tap = tms ? cjc_pkg::EXIT1_DR : cjc_pkg::SHIFT_DR;
         cjc_pkg::EXIT1_DR:
            nxt_tap = tms ? cjc_pkg::UPDATE_DR : cjc_pkg::PAUSE_DR;
         cjc_pkg::PAUSE_DR:
            nxt_tap = tms ? cjc_pkg::EXIT2_DR : cjc_pkg::PAUSE_DR;
         cjc_pkg::EXIT2_DR:
            nxt_tap = tms ? cjc_pkg::UPDATE_DR : cjc_pkg::SHIFT_DR;
         cjc_pkg::UPDATE_DR:
            nxt_tap = tms ? cjc_pkg::SELECT_DR : cjc_pkg::RUN_IDLE;
         cjc_pkg::SELECT_IR:
            nxt_tap = tms ? cjc_pkg::TEST_LOGIC_RESET : cjc_pkg::CAPTURE_IR;
         cjc_pkg::CAPTURE_IR:
            nxt_tap = tms ? cjc_pkg::EXIT1_IR : cjc_pkg::SHIFT_IR;
         cjc_pkg::SHIFT_IR:
            nxt_tap = tms ? cjc_pkg::EXIT1_IR : cjc_pkg::SHIFT_IR;
         cjc_pkg::EXIT1_IR:
            nxt_tap = tms ? cjc_pkg::UPDATE_IR : cjc_pkg::PAUSE_IR;
         cjc_pkg::PAUSE_IR:
            nxt_tap = tms ? cjc_pkg::EXIT2_IR : cjc_pkg::PAUSE_IR;
         cjc_pkg::EXIT2_IR:
            nxt_tap = tms ? cjc_pkg::UPDATE_IR : cjc_pkg::SHIFT_IR;
         cjc_pkg::UPDATE_IR:
            nxt_tap = tms ? cjc_pkg::SELECT_DR : cjc_pkg::RUN_IDLE;
         default: nxt_tap = cjc_pkg::TEST_LOGIC_RESET;
      endcase
   end

   // tap state register; five tms-high clocks reset it
   always_ff @(posedge tck) begin
      tap_ff <= nxt_tap;
   end

   // instruction shift and update; test-logic-reset loads bypass
   always_ff @(posedge tck) begin
      if (tap_ff == cjc_pkg::TEST_LOGIC_RESET) begin
         ir_ff <= `CJC_OP_BYPASS;
      end else if (tap_ff == cjc_pkg::UPDATE_IR) begin
         ir_ff <= ir_shift_ff;
      end
      if (tap_ff == cjc_pkg::CAPTURE_IR) begin
         ir_shift_ff <= `CJC_IR_CAPTURE;
      end else if (tap_ff == cjc_pkg::SHIFT_IR) begin
         ir_shift_ff <= {tdi, ir_shift_ff[`CJC_IR_LEN-1:1]};
      end
   end

   // tap state decode used by the boundary cells and the hold latch
   assign tlr = (tap_ff == cjc_pkg::TEST_LOGIC_RESET);
   assign cap_dr = (tap_ff == cjc_pkg::CAPTURE_DR);
   assign shf_dr = (tap_ff == cjc_pkg::SHIFT_DR);
   assign upd_dr = (tap_ff == cjc_pkg::UPDATE_DR);

   // instruction decode; anything not listed falls back to bypass
   always_comb begin
      in_sample = 1'b0;
      in_extest = 1'b0;
      in_idcode = 1'b0;
      in_user = 1'b0;
      in_start = 1'b0;
      in_hold = 1'b0;
      in_bypass = 1'b0;
      case (ir_ff)
         `CJC_OP_SAMPLE: begin
            in_sample = 1'b1;
         end
         `CJC_OP_EXTEST: begin
            in_extest = 1'b1;
         end
         `CJC_OP_IDCODE: begin
            in_idcode = 1'b1;
         end
         `CJC_OP_USERCODE: begin
            in_user = 1'b1;
         end
         `CJC_OP_START_RELOAD: begin
            in_start = 1'b1;
         end
         `CJC_OP_HOLD_RELOAD: begin
            in_hold = 1'b1;
         end
         `CJC_OP_BYPASS: begin
            in_bypass = 1'b1;
         end
         default: begin
            in_bypass = 1'b1;
         end
      endcase
   end

   // boundary chain is in the data path for sample and external test
   assign in_boundary = in_sample || in_extest;

   // boundary cells: capture pins, shift toward tdo, update on update-dr
   for (genvar c = 0; c < `CJC_BSR_LEN; c++) begin : g_cell
      logic shift_src;
      // the top cell takes tdi, every other cell its upper neighbour
      if (c == `CJC_BSR_LEN - 1) begin : g_last
         assign shift_src = tdi;
      end else begin : g_mid
         assign shift_src = bsr_ff[c+1];
      end
      // capture and shift stage of this cell
      always_ff @(posedge tck) begin
         if (in_boundary && cap_dr) begin
            bsr_ff[c] <= pin_levels[c];
         end else if (in_boundary && shf_dr) begin
            bsr_ff[c] <= shift_src;
         end
      end
      // update stage; holds the pattern while shifting goes on
      always_ff @(posedge tck) begin
         if (in_boundary && upd_dr) begin
            bsr_upd_ff[c] <= bsr_ff[c];
         end
      end
   end

   // 32-bit identity / user code register
   always_ff @(posedge tck) begin
      if (tap_ff == cjc_pkg::CAPTURE_DR) begin
         if (ir_ff == `CJC_OP_IDCODE) begin
            dr32_ff <= ID_VALUE;
         end else begin
            dr32_ff <= user_code;
         end
      end else if (tap_ff == cjc_pkg::SHIFT_DR) begin
         dr32_ff <= {tdi, dr32_ff[31:1]};
      end
   end

   // bypass stage, captures zero
   always_ff @(posedge tck) begin
      if (tap_ff == cjc_pkg::CAPTURE_DR) begin
         bypass_ff <= 1'b0;
      end else if (tap_ff == cjc_pkg::SHIFT_DR) begin
         bypass_ff <= tdi;
      end
   end

   // tdo mux, launched on the falling edge
   always_ff @(negedge tck) begin
      tdo_en_ff <= (tap_ff == cjc_pkg::SHIFT_DR) ||
                   (tap_ff == cjc_pkg::SHIFT_IR);
      if (tap_ff == cjc_pkg::SHIFT_IR) begin
         tdo_ff <= ir_shift_ff[0];
      end else begin
         case (ir_ff)
            `CJC_OP_SAMPLE, `CJC_OP_EXTEST: tdo_ff <= bsr_ff[0];
            `CJC_OP_IDCODE, `CJC_OP_USERCODE: tdo_ff <= dr32_ff[0];
            default: tdo_ff <= bypass_ff;
         endcase
      end
   end

   assign tdo = tdo_ff;
   assign tdo_oe_n = ~tdo_en_ff;
   assign pin_drive = bsr_upd_ff;
   assign pin_test_en = (ir_ff == `CJC_OP_EXTEST);

   // hold-reload latch: set by hold, cleared once start-reload updates
   always_ff @(posedge tck) begin
      if (tlr) begin
         hold_ff <= 1'b0; // tap reset gives a known, released state
      end else if (in_hold) begin
         hold_ff <= 1'b1;
      end else if (in_start) begin
         hold_ff <= 1'b0;
      end
   end

   // reload request low in idle under start, or while held
   assign reload_req_o = 1'b0;
   assign reload_req_oe_n =
      ~((in_start && tap_ff == cjc_pkg::RUN_IDLE) || hold_ff);

   // registered copy of the request so no decode glitch crosses domains
   always_ff @(posedge tck) begin
      req_tck_ff <= reload_req_oe_n;
   end

   // pin and reload request synchronisers into the system clock domain
   always_ff @(posedge clock) begin
      sel_sync_ff <= {sel_sync_ff[0], por_delay_select};
      en_sync_ff <= {en_sync_ff[0], enable_in};
      done_sync_ff <= {done_sync_ff[0], load_done};
      req_sync_ff <= {req_sync_ff[0], req_tck_ff};
   end

   // delay length picked by the synchronised select pin
   always_ff @(posedge clock) begin
      por_lim_ff <= sel_sync_ff[1] ? POR_SHORT_CYC : POR_LONG_CYC;
   end

   // rising edge of the synchronised enable line
   assign en_rise = en_sync_ff[1] && !en_prev_ff;

   // power-on delay, enable release and start decision
   always_ff @(posedge clock) begin
      if (srst) begin
         por_ff <= cjc_pkg::POR_WAIT;
         por_cnt_ff <= 32'h0000_0000;
         en_prev_ff <= 1'b0;
      end else begin
         en_prev_ff <= en_sync_ff[1];
         case (por_ff)
            cjc_pkg::POR_WAIT: begin
               por_cnt_ff <= por_cnt_ff + 32'h0000_0001;
               if (por_cnt_ff + 32'h0000_0001 >= por_lim_ff) begin
                  por_ff <= cjc_pkg::POR_EXTEND;
               end
            end
            cjc_pkg::POR_EXTEND: begin
               // line held low externally keeps us in reset
               if (en_rise) begin
                  por_ff <= done_sync_ff[1] ? cjc_pkg::POR_IDLE
                                            : cjc_pkg::POR_CONFIG;
               end
            end
            cjc_pkg::POR_CONFIG: por_ff <= cjc_pkg::POR_CONFIG;
            cjc_pkg::POR_IDLE: por_ff <= cjc_pkg::POR_IDLE;
            default: por_ff <= cjc_pkg::POR_WAIT;
         endcase
      end
   end

   // outputs of the power-on logic
   assign enable_o = 1'b0;
   assign enable_oe_n = (por_ff != cjc_pkg::POR_WAIT);
   assign config_start = (por_ff == cjc_pkg::POR_CONFIG) && req_sync_ff[1];
   assign config_idle = (por_ff == cjc_pkg::POR_IDLE);
endmodule // cjc_config_jtag_control

/* File: testbench/cjc_props.sv */
`timescale 1ns/1ns
module cjc_props #(
   parameter int unsigned POR_SHORT_CYC = 20,
   parameter int unsigned POR_LONG_CYC = 50
) (
   input wire logic clock, // clock
   input wire logic srst, // reset
   input wire logic por_delay_select, // delay pick
   input wire logic enable_in, // enable line
   input wire logic load_done, // fpga done
   input wire logic enable_o, // tied low
   input wire logic enable_oe_n, // enable pull
   input wire logic reload_req_o, // tied low
   input wire logic config_start, // go
   input wire logic config_idle // locked
);
   int unsigned cnt_ff;
   int unsigned lim;
   // delay chosen by the select pin
   assign lim = por_delay_select ? POR_SHORT_CYC : POR_LONG_CYC;
   // clocks since reset release
   always_ff @(posedge clock) begin
      cnt_ff <= srst ? 0 : cnt_ff + 1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   sequence s_line_up;
      $rose(enable_in) && enable_oe_n;
   endsequence
   sequence s_decided;
      config_start || config_idle;
   endsequence
   a_drive_tied: assert property (!enable_o && !reload_req_o)
      else $error("open-drain data not low");
   a_por_hold: assert property (cnt_ff + 2 < lim |-> !enable_oe_n)
      else $error("enable line released early");
   a_por_release: assert property (cnt_ff == lim + 4 |-> enable_oe_n)
      else $error("enable line not released");
   a_decide_soon: assert property (s_line_up |-> ##[1:4] s_decided)
      else $error("no decision after enable rise");
   a_idle_cause: assert property ($rose(config_idle) |-> $past(load_done, 3))
      else $error("idle without load done");
   a_idle_sticky: assert property (config_idle |=> config_idle)
      else $error("idle mode left");
   a_modes_apart: assert property (!(config_idle && config_start))
      else $error("idle and start together");
   a_cfg_after_por: assert property (s_decided |-> enable_oe_n)
      else $error("decision while enable held");
endmodule // cjc_props
bind cjc_config_jtag_control cjc_props #(.POR_SHORT_CYC(POR_SHORT_CYC),
   .POR_LONG_CYC(POR_LONG_CYC)) u_props (.clock(clock), .srst(srst),
   .por_delay_select(por_delay_select), .enable_in(enable_in),
   .load_done(load_done), .enable_o(enable_o), .enable_oe_n(enable_oe_n),
   .reload_req_o(reload_req_o), .config_start(config_start),
   .config_idle(config_idle));

/* File: testbench/cjc_fpga_model.sv */
`timescale 1ns/1ns
module cjc_fpga_model (
   input wire logic clock, // clock
   input wire logic srst, // reset
   input wire logic reload_oe_n, // low pulls reload
   input wire logic enable_oe_n, // low pulls enable
   input wire logic late, // powers up after por
   input wire logic ext_hold, // holds enable low
   output logic enable_in, // enable level
   output logic load_done, // done level
   output int loads // loads begun
);
   logic reload_ff;
   // pull-up on the enable line, external hold wins
   assign enable_in = enable_oe_n & ~ext_hold;
   assign load_done = late;
   // reload low keeps this side in reset, flash pins released
   // a power-good hold would simply extend that low phase
   // a load begins only as the reload line goes high
   always @(posedge clock) begin
      reload_ff <= reload_oe_n;
      if (srst) loads <= 0;
      else if (reload_oe_n === 1'b1 && reload_ff === 1'b0) loads <= loads + 1;
   end
endmodule // cjc_fpga_model

/* File: testbench/cjc_config_jtag_control_test.sv */
`timescale 1ns/1ns
`include "cjc_params.svh"
module cjc_config_jtag_control_test;
   logic clock = 0, srst = 1, tck = 0, tms = 1, tdi = 0, sel = 1;
   logic late = 0, hold = 0, tq, tdo, tdo_oe_n, rq_o, rq_oe_n;
   logic en_o, en_oe_n, en_in, ld, cs, ci, test_en;
   logic [31:0] ucode = 32'ha5c3_0f96;
   logic [173:0] pins = {6'h2d, {21{8'h96}}};
   logic [173:0] drv, o;
   int loads, n, bad_count = 0, comparisons = 0, cyc = 0;
   always #20 clock = ~clock;
   cjc_config_jtag_control #(.POR_SHORT_CYC(20), .POR_LONG_CYC(50),
      .ID_VALUE(32'h0f0f_5aa5)) u_dut (.clock(clock), .srst(srst),
      .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
      .user_code(ucode), .pin_levels(pins), .pin_drive(drv),
      .pin_test_en(test_en), .reload_req_o(rq_o),
      .reload_req_oe_n(rq_oe_n), .por_delay_select(sel),
      .enable_in(en_in), .enable_o(en_o), .enable_oe_n(en_oe_n),
      .load_done(ld), .config_start(cs), .config_idle(ci));
   cjc_fpga_model u_fpga (.clock(clock), .srst(srst), .reload_oe_n(rq_oe_n),
      .enable_oe_n(en_oe_n), .late(late), .ext_hold(hold),
      .enable_in(en_in), .load_done(ld), .loads(loads));
   task final_report;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [173:0] g, input logic [173:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one tck period, tdo taken before the rising edge
   task tap(input logic m, input logic d);
      tms = m;
      tdi = d;
      #24 tq = tdo;
      tck = 1;
      #24 tck = 0;
   endtask
   task scan(input logic ir, input int k, input logic [173:0] i);
      tap(1, 0);
      if (ir) tap(1, 0);
      tap(0, 0);
      tap(0, 0);
      for (int j = 0; j < k; j++) begin
         tap(j == k - 1, i[j]);
         o[j] = tq;
      end
      tap(1, 0);
      tap(0, 0);
   endtask
   task rst(input logic s, input logic l);
      @(negedge clock);
      srst = 1;
      sel = s;
      late = l;
      repeat (5) tap(1, 0);
      tap(0, 0);
      repeat (16) @(negedge clock);
      srst = 0;
   endtask
   task wait_cfg;
      repeat (200) begin
         @(negedge clock);
         if (cs === 1'b1 || ci === 1'b1) break;
      end
   endtask
   task t_por;
      rst(1, 0);
      wait_cfg;
      chk({ci, cs}, 2'b01);
      $display("t_por done");
   endtask
   task t_tap;
      repeat (5) tap(1, 0);
      tap(0, 0);
      scan(1, 10, `CJC_OP_IDCODE);
      chk(o[9:0], `CJC_IR_CAPTURE);
      scan(0, 32, 0);
      chk(o[31:0], 32'h0f0f_5aa5);
      scan(1, 10, `CJC_OP_USERCODE);
      scan(0, 32, 0);
      chk(o[31:0], ucode);
      for (int j = 0; j < 2; j++) begin
         scan(1, 10, j ? 10'h2aa : `CJC_OP_BYPASS);
         scan(0, 3, 3'b101);
         chk(o[2:0], 3'b010);
      end
      $display("t_tap done");
   endtask
   // boundary tests run after t_por and t_tap, whether or not config_start went high
   task t_bsr;
      scan(1, 10, `CJC_OP_SAMPLE);
      chk(test_en, 0);
      scan(0, 174, ~pins);
      chk(o, pins);
      scan(1, 10, `CJC_OP_EXTEST);
      chk({test_en, drv}, {1'b1, ~pins});
      scan(0, 174, 0);
      chk(o, pins);
      $display("t_bsr done");
   endtask
   task t_reload;
      for (int j = 0; j < 2; j++) begin
         if (j) scan(1, 10, `CJC_OP_HOLD_RELOAD);
         if (j) scan(0, 32, 0);
         chk(rq_oe_n, !j);
         if (j) scan(1, 10, `CJC_OP_BYPASS);
         chk(rq_oe_n, !j);
         scan(1, 10, `CJC_OP_START_RELOAD);
         chk(rq_oe_n, 0);
         n = loads;
         tap(1, 0);
         chk(rq_oe_n, 1);
         repeat (3) @(negedge clock);
         chk(loads - n, 1);
         tap(1, 0);
         tap(1, 0);
         tap(0, 0);
      end
      $display("t_reload done");
   endtask
   task t_idle;
      hold = 1;
      rst(0, 1);
      repeat (70) @(negedge clock);
      chk({ci, cs}, 0);
      hold = 0;
      wait_cfg;
      chk({ci, cs}, 2'b10);
      late = 0;
      hold = 1;
      repeat (4) @(negedge clock);
      hold = 0;
      repeat (8) @(negedge clock);
      chk({ci, cs}, 2'b10);
      $display("t_idle done");
   endtask
   // cut a hang short
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         final_report;
      end
   end
   initial begin
      t_por;
      t_tap;
      t_bsr;
      t_reload;
      t_idle;
      final_report;
   end
endmodule // cjc_config_jtag_control_test
